// >>> dv/link_event_model.sv
// Model of the root-port link logic that raises event strobes.
// Assumes the bench gates activity; a quiet link drives all strobes low.
`timescale 1ns/100ps
module link_event_model (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // Gate from the bench
  input  wire logic                  run_i,
  // Event strobes
  output perf_cnt_pkg::link_events_t events_o
);
  int                         seed = 96081;
  logic [63:0]                r;
  perf_cnt_pkg::link_events_t ev;

  initial events_o = '0;
  // Retry and error bits are fresh each cycle, so a bit can stay high for several cycles in a row
  always @(posedge ref_clk_i) begin
    r = {$random(seed), $random(seed)};
    if (rst_i || !run_i) begin
      events_o <= '0;
    end else begin
      ev = r[35:0];
      // A port sits in exactly one link state: Active_state_busy, Active_state_idle, L1 or none
      for (int p = 0; p < 4; p++) begin
        ev.active_state_busy[p] = (r[36+2*p +: 2] == 2'h0);
        ev.active_state_idle[p] = (r[36+2*p +: 2] == 2'h1);
        ev.low_power_state[p]   = (r[36+2*p +: 2] == 2'h2);
      end
      events_o <= ev;
    end
  end
endmodule

// >>> dv/pcie_root_port_event_counters_tb.sv
// Self-checking bench for the root-port event counter unit.
// Assumes the link model is quiet whenever registers are accessed.
`timescale 1ns/100ps
module pcie_root_port_event_counters_tb;
  logic                       ref_clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwdata = 32'h0;
  logic [31:0]                prdata;
  logic [31:0]                rd;
  logic                       pready;
  logic                       pslverr;
  logic                       err;
  logic                       run = 1'b0;
  logic                       frz = 1'b0;
  perf_cnt_pkg::link_events_t events;
  perf_cnt_pkg::ctl_t         ctl [4];
  logic [47:0]                exp_cnt [4];
  int                         n_fail = 0;
  int                         compares = 0;
  int                         seed = 96081;

  always #50 ref_clk_i = ~ref_clk_i;

  pcie_root_port_event_counters i_pcie_root_port_event_counters (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .events_i(events));
  link_event_model i_link_event_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .run_i(run), .events_o(events));

  // ----------------------------------------------------------------
  // Reference counting
  // ----------------------------------------------------------------
  function automatic logic [47:0] inc(perf_cnt_pkg::ctl_t c, perf_cnt_pkg::link_events_t e, int n);
    logic [3:0] lvl;
    lvl = (c.umask[0] ? e.active_state_busy : 4'h0) | (c.umask[1] ? e.low_power_state : 4'h0)
        | (c.umask[2] ? e.active_state_idle : 4'h0);
    if (!c.enable) return 48'h0;
    if (c.ev_sel[7]) return (n == 0) ? {40'h0, e.occupancy} : 48'h0;
    case (c.ev_sel)
      8'h16: return {47'h0, |(e.inbound_busy_cycles & c.umask[3:0])};
      8'h17: return {47'h0, |(e.outbound_busy_cycles & c.umask[3:0])};
      8'h18: return {47'h0, |(lvl & c.umask[7:4])};
      8'h1E: return {47'h0, |(e.link_retry & c.umask[3:0])};
      8'h1F: return {47'h0, |(e.correctable_error_count & c.umask[3:0])};
      default: return 48'h0;
    endcase
  endfunction

  // Only counts while strobes are live, so register-side updates never race it
  always @(posedge ref_clk_i) begin
    if (!rst_i && !frz && events != '0) begin
      for (int n = 0; n < 4; n++) exp_cnt[n] <= exp_cnt[n] + inc(ctl[n], events, n);
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // No assumed latency: only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask

  task automatic setctl(input int n, input perf_cnt_pkg::ctl_t c);
    apb(1'b1, 8'(4 * n), c | 32'hFFBF_0000);
    ctl[n] = c;
    rdchk(8'(4 * n), c);
  endtask

  task automatic rdall;
    for (int n = 0; n < 4; n++) begin
      rdchk(8'(8'h10 + 8 * n), exp_cnt[n][31:0]);
      rdchk(8'(8'h14 + 8 * n), {16'h0, exp_cnt[n][47:32]});
    end
  endtask

  task automatic burst(input int cyc);
    run <= 1'b1;
    repeat (cyc) @(posedge ref_clk_i);
    run <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_fail++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    static logic [7:0]  codes [7] = '{8'h16, 8'h17, 8'h18, 8'h1E, 8'h1F, 8'h80, 8'h20};
    perf_cnt_pkg::ctl_t c;
    for (int n = 0; n < 4; n++) begin
      ctl[n] = '0;
      exp_cnt[n] = '0;
    end
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    for (int a = 0; a < 8'h38; a += 4) rdchk(8'(a), 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("Test reset done");
    // All-ones mask on counter 0 and a disabled counter 3 on even passes
    foreach (codes[k]) begin
      for (int n = 0; n < 4; n++) begin
        c = '0;
        c.ev_sel = codes[k];
        c.umask = (n == 0) ? 8'hFF : 8'($random(seed));
        c.enable = (n < 3) || k[0];
        setctl(n, c);
      end
      burst(150);
      rdall();
      $display("Test code %h done", codes[k]);
    end
    c = '0;
    c.ev_sel = 8'h18;
    c.umask = 8'hFF;
    c.enable = 1'b1;
    setctl(1, c);
    apb(1'b1, 8'h18, 32'hFFFF_FFF0);
    apb(1'b1, 8'h1C, 32'h0000_FFFF);
    exp_cnt[1] = 48'hFFFF_FFFF_FFF0;
    burst(60);
    rdall();
    rdchk(8'h34, 32'h2);
    apb(1'b1, 8'h34, 32'hF);
    rdchk(8'h34, 32'h0);
    $display("Test wrap done");
    apb(1'b1, 8'h30, 32'h3);
    frz = 1'b1;
    for (int n = 0; n < 4; n++) exp_cnt[n] = '0;
    burst(40);
    rdall();
    rdchk(8'h30, 32'h1);
    $display("Test freeze and clear done");
    end_sim();
  end
endmodule

// >>> dv/perf_cnt_props.sv
// Checker for the APB side of the event counter unit.
// Assumes it sees only the top module's ports, attached by the bind below.
`timescale 1ns/100ps
module perf_cnt_props (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Transfer timing and responses
  // ----------------------------------------------------------------
  wire acc    = psel_i && penable_i && !pready_o;
  wire rd_ctl = acc && !pwrite_i && paddr_i < 8'h10;
  wire rd_hi  = acc && !pwrite_i && paddr_i inside {8'h14, 8'h1C, 8'h24, 8'h2C};

  a_one_wait: assert property (acc |=> pready_o) else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i)) else $error("stray ready");
  a_unmapped_err: assert property (acc && paddr_i >= 8'h38 |=> pslverr_o && prdata_o == 32'h0) else $error("no refusal");
  a_mapped_ok: assert property (acc && paddr_i < 8'h38 && paddr_i[1:0] == 2'h0 |=> !pslverr_o) else $error("false error");
  a_ctl_rsvd: assert property (rd_ctl |=> prdata_o[31:23] == 9'h0 && prdata_o[21:16] == 6'h0) else $error("ctl rsvd");
  a_hi_width: assert property (rd_hi |=> prdata_o[31:16] == 16'h0) else $error("counter over 48 bits");
  a_data_hold: assert property (!pready_o ##1 !pready_o |-> $stable(prdata_o)) else $error("read data moved");

  c_write: cover property (acc && pwrite_i);
  c_refused: cover property (pready_o && pslverr_o);
  c_hi_read: cover property (rd_hi);
endmodule

bind pcie_root_port_event_counters perf_cnt_props i_perf_cnt_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

// >>> logic/event_counter_slice.sv
// One 48-bit event counter with its event selection.
// Assumes event strobes are synchronous to ref_clk_i; loads come from the APB slave.
`timescale 1ns/100ps
module event_counter_slice #(
  parameter bit OCC_CAPABLE = 1'b0
) (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  // Control
  input  perf_cnt_pkg::ctl_t              ctl_i,
  input  wire logic                       freeze_i,
  input  wire logic                       clear_i,
  // Events
  input  perf_cnt_pkg::link_events_t      ev_i,
  // Software load
  input  wire logic                       wr_lo_i,
  input  wire logic                       wr_hi_i,
  input  wire logic [31:0]                wdata_i,
  // Status
  output logic [perf_cnt_pkg::CTR_W-1:0]  count_o,
  output logic                            wrap_o
);

  logic [perf_cnt_pkg::CTR_W-1:0] count_r;
  logic [perf_cnt_pkg::CTR_W-1:0] count_nxt;
  logic                           wrap_r;
  logic                           wrap_nxt;
  logic [perf_cnt_pkg::CTR_W:0]   sum;
  logic [perf_cnt_pkg::CTR_W-1:0] incr;
  logic                           hit;

  function automatic logic any_port(input logic [perf_cnt_pkg::NUM_PORTS-1:0] vec,
                                    input logic [perf_cnt_pkg::NUM_PORTS-1:0] sel);
    any_port = |(vec & sel);
  endfunction

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  always_comb begin
    logic [perf_cnt_pkg::NUM_PORTS-1:0] port_sel;
    logic [perf_cnt_pkg::NUM_PORTS-1:0] link_sel;
    port_sel = ctl_i.umask[perf_cnt_pkg::NUM_PORTS-1:0];
    link_sel = ctl_i.umask[perf_cnt_pkg::UM_PORT_LSB +: perf_cnt_pkg::NUM_PORTS];
    hit      = 1'b0;
    incr     = '0;
    if (ctl_i.ev_sel[perf_cnt_pkg::OCC_SEL_BIT]) begin
      // Occupancy adds a level, not a strobe; other slices ignore it
      if (OCC_CAPABLE) begin
        incr = {{(perf_cnt_pkg::CTR_W-perf_cnt_pkg::OCC_W){1'b0}}, ev_i.occupancy};
      end
    end else begin
      unique case (ctl_i.ev_sel)
        perf_cnt_pkg::EV_INBOUND_BUSY:  hit = any_port(ev_i.inbound_busy_cycles, port_sel);
        perf_cnt_pkg::EV_OUTBOUND_BUSY: hit = any_port(ev_i.outbound_busy_cycles, port_sel);
        perf_cnt_pkg::EV_LINK_CYCLES: begin
          hit = (ctl_i.umask[perf_cnt_pkg::UM_ACT_BUSY] && any_port(ev_i.active_state_busy, link_sel))
             || (ctl_i.umask[perf_cnt_pkg::UM_L1]       && any_port(ev_i.low_power_state, link_sel))
             || (ctl_i.umask[perf_cnt_pkg::UM_ACT_IDLE] && any_port(ev_i.active_state_idle, link_sel));
        end
        perf_cnt_pkg::EV_LINK_RETRY:    hit = any_port(ev_i.link_retry, port_sel);
        perf_cnt_pkg::EV_CORR_ERROR:    hit = any_port(ev_i.correctable_error_count, port_sel);
        default:                        hit = 1'b0;
      endcase
      incr = {{(perf_cnt_pkg::CTR_W-1){1'b0}}, hit};
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    sum       = {1'b0, count_r} + {1'b0, incr};
    count_nxt = count_r;
    wrap_nxt  = 1'b0;
    if (clear_i) begin
      count_nxt = '0;
    end else if (wr_lo_i || wr_hi_i) begin
      // Software load wins over a same-cycle event
      if (wr_lo_i) begin
        count_nxt[31:0] = wdata_i;
      end
      if (wr_hi_i) begin
        count_nxt[perf_cnt_pkg::CTR_W-1:32] = wdata_i[perf_cnt_pkg::HI_W-1:0];
      end
    end else if (ctl_i.enable && !freeze_i) begin
      count_nxt = sum[perf_cnt_pkg::CTR_W-1:0];
      wrap_nxt  = sum[perf_cnt_pkg::CTR_W];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      wrap_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      wrap_r  <= wrap_nxt;
    end
  end

  assign count_o = count_r;
  assign wrap_o  = wrap_r;

endmodule

// >>> logic/pcie_root_port_event_counters.sv
// Root-port event counting unit: four counters behind an APB register slave.
// Assumes event strobes come from link logic on ref_clk_i and need no synchroniser.
`timescale 1ns/100ps
module pcie_root_port_event_counters (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic [31:0]                     prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Root-port link events
  input  perf_cnt_pkg::link_events_t      events_i
);

  localparam int N = perf_cnt_pkg::NUM_CTRS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  perf_cnt_pkg::apb_req_t         req;
  perf_cnt_pkg::ctl_t             ctl_r [N];
  perf_cnt_pkg::ctl_t             ctl_nxt [N];
  logic [perf_cnt_pkg::CTR_W-1:0] count [N];
  logic [N-1:0]                   wrap;
  logic [N-1:0]                   wr_lo;
  logic [N-1:0]                   wr_hi;
  logic [N-1:0]                   wrap_stat_r;
  logic [N-1:0]                   wrap_stat_nxt;
  logic                           freeze_r;
  logic                           freeze_nxt;
  logic                           clear_r;
  logic                           clear_nxt;
  logic [31:0]                    prdata_r;
  logic [31:0]                    prdata_nxt;
  logic                           pready_r;
  logic                           pready_nxt;
  logic                           pslverr_r;
  logic                           pslverr_nxt;
  logic                           wr_go;

  assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] ctl_addr(input int idx);
    ctl_addr = perf_cnt_pkg::CTL_BASE + 8'(idx) * perf_cnt_pkg::CTL_STRIDE;
  endfunction

  function automatic logic [7:0] ctr_addr(input int idx);
    ctr_addr = perf_cnt_pkg::CTR_BASE + 8'(idx) * perf_cnt_pkg::CTR_STRIDE;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == perf_cnt_pkg::UNIT_CTL) || (a == perf_cnt_pkg::WRAP_STAT);
    for (int i = 0; i < N; i++) begin
      if (a == ctl_addr(i) || a == ctr_addr(i) || a == ctr_addr(i) + perf_cnt_pkg::CTR_HI_OFS) begin
        mapped = 1'b1;
      end
    end
  endfunction

  // Writes land only on the edge that completes the access phase
  assign wr_go = req.psel && req.penable && pready_r && req.pwrite && mapped(req.paddr);

  // ----------------------------------------------------------------
  // Counter slices
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ctr
      assign wr_lo[g] = wr_go && (req.paddr == ctr_addr(g));
      assign wr_hi[g] = wr_go && (req.paddr == ctr_addr(g) + perf_cnt_pkg::CTR_HI_OFS);

      event_counter_slice #(
        .OCC_CAPABLE (g == 0)
      ) u_slice (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ctl_i     (ctl_r[g]),
        .freeze_i  (freeze_r),
        .clear_i   (clear_r),
        .ev_i      (events_i),
        .wr_lo_i   (wr_lo[g]),
        .wr_hi_i   (wr_hi[g]),
        .wdata_i   (req.pwdata),
        .count_o   (count[g]),
        .wrap_o    (wrap[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < N; i++) begin
      ctl_nxt[i] = ctl_r[i];
      if (wr_go && req.paddr == ctl_addr(i)) begin
        ctl_nxt[i] = perf_cnt_pkg::ctl_t'(req.pwdata);
        // Reserved fields stay zero
        ctl_nxt[i].rsvd_hi = '0;
        ctl_nxt[i].rsvd_lo = '0;
      end
    end
    freeze_nxt    = freeze_r;
    clear_nxt     = 1'b0;
    wrap_stat_nxt = wrap_stat_r;
    if (wr_go && req.paddr == perf_cnt_pkg::UNIT_CTL) begin
      freeze_nxt = req.pwdata[perf_cnt_pkg::FREEZE_BIT];
      clear_nxt  = req.pwdata[perf_cnt_pkg::CLEAR_BIT];
    end
    if (wr_go && req.paddr == perf_cnt_pkg::WRAP_STAT) begin
      wrap_stat_nxt = wrap_stat_nxt & ~req.pwdata[N-1:0];
    end
    // A wrap in the clearing cycle stays recorded
    wrap_stat_nxt = wrap_stat_nxt | wrap;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        ctl_r[i] <= perf_cnt_pkg::CTL_RESET;
      end
      freeze_r    <= 1'b0;
      clear_r     <= 1'b0;
      wrap_stat_r <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        ctl_r[i] <= ctl_nxt[i];
      end
      freeze_r    <= freeze_nxt;
      clear_r     <= clear_nxt;
      wrap_stat_r <= wrap_stat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, read data captured in it
  // ----------------------------------------------------------------
  always_comb begin
    pready_nxt  = req.psel && req.penable && !pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (pready_nxt) begin
      prdata_nxt  = 32'h0000_0000;
      pslverr_nxt = !mapped(req.paddr);
      if (!req.pwrite) begin
        for (int i = 0; i < N; i++) begin
          if (req.paddr == ctl_addr(i)) begin
            prdata_nxt = 32'(ctl_r[i]);
          end
          if (req.paddr == ctr_addr(i)) begin
            prdata_nxt = count[i][31:0];
          end
          if (req.paddr == ctr_addr(i) + perf_cnt_pkg::CTR_HI_OFS) begin
            prdata_nxt = {{(32-perf_cnt_pkg::HI_W){1'b0}}, count[i][perf_cnt_pkg::CTR_W-1:32]};
          end
        end
        if (req.paddr == perf_cnt_pkg::UNIT_CTL) begin
          prdata_nxt[perf_cnt_pkg::FREEZE_BIT] = freeze_r;
        end
        if (req.paddr == perf_cnt_pkg::WRAP_STAT) begin
          prdata_nxt[N-1:0] = wrap_stat_r;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;

endmodule

// >>> shared/perf_cnt_pkg.sv
// Constants, field layouts and carriers for the root-port event counter unit.
// Assumes one uncore clock shared by the link logic and the APB register slave.
package perf_cnt_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          NUM_CTRS    = 4;
  localparam int          NUM_PORTS   = 4;
  localparam int          CTR_W       = 48;
  localparam int          HI_W        = CTR_W - 32;
  localparam int          ADDR_W      = 8;
  localparam int          OCC_W       = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTL_BASE    = 8'h00;
  localparam logic [7:0]  CTL_STRIDE  = 8'h04;
  localparam logic [7:0]  CTR_BASE    = 8'h10;
  localparam logic [7:0]  CTR_STRIDE  = 8'h08;
  localparam logic [7:0]  CTR_HI_OFS  = 8'h04;
  localparam logic [7:0]  UNIT_CTL    = 8'h30;
  localparam logic [7:0]  WRAP_STAT   = 8'h34;

  // Unit control bits
  localparam int          FREEZE_BIT  = 0;
  localparam int          CLEAR_BIT   = 1;

  // ----------------------------------------------------------------
  // Event codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  EV_INBOUND_BUSY  = 8'h16;
  localparam logic [7:0]  EV_OUTBOUND_BUSY = 8'h17;
  localparam logic [7:0]  EV_LINK_CYCLES   = 8'h18;
  localparam logic [7:0]  EV_LINK_RETRY    = 8'h1E;
  localparam logic [7:0]  EV_CORR_ERROR    = 8'h1F;
  localparam int          OCC_SEL_BIT      = 7;

  // Unit-mask layout for the link-state event
  localparam int          UM_ACT_BUSY  = 0;
  localparam int          UM_L1        = 1;
  localparam int          UM_ACT_IDLE  = 2;
  localparam int          UM_PORT_LSB  = 4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0]  rsvd_hi;
    logic        enable;
    logic [5:0]  rsvd_lo;
    logic [7:0]  umask;
    logic [7:0]  ev_sel;
  } ctl_t;

  localparam ctl_t        CTL_RESET   = '0;

  typedef struct packed {
    logic [NUM_PORTS-1:0] inbound_busy_cycles;
    logic [NUM_PORTS-1:0] outbound_busy_cycles;
    logic [NUM_PORTS-1:0] active_state_busy;
    logic [NUM_PORTS-1:0] low_power_state;
    logic [NUM_PORTS-1:0] active_state_idle;
    logic [NUM_PORTS-1:0] link_retry;
    logic [NUM_PORTS-1:0] correctable_error_count;
    logic [OCC_W-1:0]     occupancy;
  } link_events_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage
